// ==== rtl/prsd_top.sv ====
// Purpose: reset-time clock ratio straps, decode, clock enables, AXI4-Lite status
// Assumes: straps synchronous to CLOCK; board holds them through reset
// Notes: CLK_EN low freezes all state; SYS_RST still wins everywhere but the strap capture, which samples only while CLK_EN is high
`timescale 1ns/1ps
`include "prsd_map.svh"
module prsd_top (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    // straps
    input  wire logic [3:0]  PLAT_RATIO_STRAPS_I,
    output logic             STRAP_PU_EN,
    input  wire logic        CORE_RATIO_STRAP_HIGH_I,
    output logic             CORE_RATIO_STRAP_HIGH_O,
    output logic             CORE_RATIO_STRAP_HIGH_OE,
    input  wire logic        CORE_RATIO_STRAP_LOW_I,
    output logic             CORE_RATIO_STRAP_LOW_O,
    output logic             CORE_RATIO_STRAP_LOW_OE,
    input  wire logic        PCI_WIDTH_STRAP_I,
    output logic             RESET_DRIVEN_O,
    output logic             RESET_DRIVEN_OE,
    // decoded clocking
    output logic [4:0]       PLAT_MULT,
    output logic [3:0]       CORE_RATIO_X2,
    output logic             PLAT_RATIO_RESERVED,
    output logic             PCI64,
    output logic             L2_CLK_EN,
    output logic             MEM_DATA_CLK_EN,
    output logic             CORE_COMPLEX_BUS_CLK_EN,
    output logic             MEM_BUS_CLK,
    // AXI4-Lite slave
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    prsd_pkg::prsd_phase_e  phase;
    prsd_pkg::prsd_phase_e  next_phase;
    prsd_pkg::prsd_straps_s straps;
    prsd_pkg::prsd_ratio_s  dec;
    // ctrl: run bit and the two strap pin out values
    logic [`PRSD_CT_W-1:0]  ctrl;
    logic                   plat_tick;
    logic [`PRSD_AW-1:0]    aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   aw_held;
    logic                   w_held;
    logic                   wr_fire;
    logic [31:0]            rd_word;
    logic                   rd_hit;

    // ----------------------------------------
    // reset phase sequence
    // ----------------------------------------
    // latch one edge after release, run one edge later
    // straps settle through reset, so no extra wait is needed

    always_comb begin
        case (phase)
            prsd_pkg::PRSD_PH_RESET: next_phase = prsd_pkg::PRSD_PH_LATCH;
            prsd_pkg::PRSD_PH_LATCH: next_phase = prsd_pkg::PRSD_PH_RUN;
            prsd_pkg::PRSD_PH_RUN:   next_phase = prsd_pkg::PRSD_PH_RUN;
            default:                 next_phase = prsd_pkg::PRSD_PH_RESET;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            phase <= prsd_pkg::PRSD_PH_RESET;
        end else if (CLK_EN) begin
            phase <= next_phase;
        end
    end

    // ----------------------------------------
    // strap capture
    // ----------------------------------------
    // pull-ups and board drive both act only while reset holds
    // sampled every cycle of reset that has CLK_EN high, frozen from release on, so ratios cannot move
    always_ff @(posedge CLOCK) begin
        if (SYS_RST && CLK_EN) begin
            straps.plat_code     <= PLAT_RATIO_STRAPS_I;
            straps.core_code     <= {CORE_RATIO_STRAP_HIGH_I, CORE_RATIO_STRAP_LOW_I};
            straps.pci_width_pin <= PCI_WIDTH_STRAP_I;
        end
    end

    prsd_decode u_decode (
        .straps (straps),
        .ratio  (dec)
    );

    // decoded values registered once, after release
    // reserved code keeps the multiplier at zero
    // fixed until the next reset, whatever the straps do
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PLAT_MULT           <= `PRSD_PLAT_NONE;
            CORE_RATIO_X2       <= '0;
            PLAT_RATIO_RESERVED <= 1'b0;
            PCI64               <= 1'b0;
        end else if (CLK_EN && phase == prsd_pkg::PRSD_PH_LATCH) begin
            PLAT_MULT           <= dec.plat_mult;
            CORE_RATIO_X2       <= dec.core_x2;
            PLAT_RATIO_RESERVED <= dec.reserved;
            PCI64               <= dec.pci64;
        end
    end

    // ----------------------------------------
    // pin drive around reset
    // ----------------------------------------
    // oe held low until run, so board straps are never fought
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            STRAP_PU_EN              <= 1'b1;
            CORE_RATIO_STRAP_HIGH_OE <= 1'b0;
            CORE_RATIO_STRAP_LOW_OE  <= 1'b0;
            RESET_DRIVEN_OE          <= 1'b1;
        end else if (CLK_EN) begin
            STRAP_PU_EN              <= 1'b0;
            CORE_RATIO_STRAP_HIGH_OE <= (phase == prsd_pkg::PRSD_PH_RUN);
            CORE_RATIO_STRAP_LOW_OE  <= (phase == prsd_pkg::PRSD_PH_RUN);
            RESET_DRIVEN_OE          <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            CORE_RATIO_STRAP_HIGH_O <= 1'b0;
            CORE_RATIO_STRAP_LOW_O  <= 1'b0;
            RESET_DRIVEN_O          <= 1'b0;
        end else if (CLK_EN) begin
            CORE_RATIO_STRAP_HIGH_O <= ctrl[`PRSD_CT_HI_OUT];
            CORE_RATIO_STRAP_LOW_O  <= ctrl[`PRSD_CT_LO_OUT];
            RESET_DRIVEN_O          <= 1'b1;
        end
    end

    // ----------------------------------------
    // platform clock enables
    // ----------------------------------------
    // no clocks on a reserved code: a bad strap must not run the fabric
    // enables registered so all three rise on the same edge
    // memory bus clock toggles on every tick: half rate
    assign plat_tick = (phase == prsd_pkg::PRSD_PH_RUN) && ctrl[`PRSD_CT_RUN]
                       && !PLAT_RATIO_RESERVED;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            L2_CLK_EN               <= 1'b0;
            MEM_DATA_CLK_EN         <= 1'b0;
            CORE_COMPLEX_BUS_CLK_EN <= 1'b0;
        end else if (CLK_EN) begin
            L2_CLK_EN               <= plat_tick;
            MEM_DATA_CLK_EN         <= plat_tick;
            CORE_COMPLEX_BUS_CLK_EN <= plat_tick;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            MEM_BUS_CLK <= 1'b0;
        end else if (CLK_EN && plat_tick) begin
            MEM_BUS_CLK <= ~MEM_BUS_CLK;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // aw and w taken in either order; response waits for both
    // one write in flight: readies stay low until b is taken

    // a held pair fires once bvalid is clear
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            S_AXI_AWREADY <= 1'b1;
        end else if (CLK_EN) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held       <= 1'b1;
                aw_addr       <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_AWREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            w_held       <= 1'b0;
            w_data       <= `PRSD_ZERO32;
            w_strb       <= '0;
            S_AXI_WREADY <= 1'b1;
        end else if (CLK_EN) begin
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held       <= 1'b1;
                w_data       <= S_AXI_WDATA;
                w_strb       <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PRSD_RESP_OKAY;
        end else if (CLK_EN) begin
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                // status and ratio are read-only; writes there are refused
                S_AXI_BRESP  <= (aw_addr == `PRSD_OFS_CTRL) ? `PRSD_RESP_OKAY
                                                            : `PRSD_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctrl <= `PRSD_CTRL_RST;
        end else if (CLK_EN && wr_fire && aw_addr == `PRSD_OFS_CTRL && w_strb[0]) begin
            ctrl <= w_data[`PRSD_CT_W-1:0];
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    // unmapped reads answer slverr with zero data
    // read word taken at the ar edge, held until rready

    always_comb begin
        rd_word = `PRSD_ZERO32;
        rd_hit  = 1'b1;
        case (S_AXI_ARADDR)
            `PRSD_OFS_STATUS: begin
                rd_word[`PRSD_ST_PLAT_LSB +: 4] = straps.plat_code;
                rd_word[`PRSD_ST_CORE_LSB +: 2] = straps.core_code;
                rd_word[`PRSD_ST_PCI64]         = PCI64;
                rd_word[`PRSD_ST_RSVD]          = PLAT_RATIO_RESERVED;
                rd_word[`PRSD_ST_RUN]           = (phase == prsd_pkg::PRSD_PH_RUN);
            end
            `PRSD_OFS_RATIO: begin
                rd_word[`PRSD_RT_PLAT_LSB +: `PRSD_PLAT_W] = PLAT_MULT;
                rd_word[`PRSD_RT_CORE_LSB +: `PRSD_CORE_W] = CORE_RATIO_X2;
            end
            `PRSD_OFS_CTRL: begin
                rd_word[`PRSD_CT_W-1:0] = ctrl;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= `PRSD_ZERO32;
            S_AXI_RRESP   <= `PRSD_RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RDATA   <= rd_word;
                S_AXI_RRESP   <= rd_hit ? `PRSD_RESP_OKAY : `PRSD_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule // prsd_top

// ==== rtl/prsd_map.svh ====
// Purpose: constants for the reset-time clock ratio strap decoder
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: offsets are byte addresses on a 32-bit AXI4-Lite slave
// Function
// - sample four platform ratio straps at power-up
// - platform ratio decode table, reserved codes flagged
// - sample two core ratio straps at power-up
// - core ratio decode 2, 2.5, 3, 3.5
// - one platform clock feeds cache, memory, bus
// - memory bus clock is half platform clock
// - strap pull-ups enabled only during reset
// - pci width strap low selects 64-bit
// - some outputs actively driven during reset
// - strap pins become outputs after reset
`ifndef PRSD_MAP_SVH
`define PRSD_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PRSD_OFS_STATUS   4'h0
`define PRSD_OFS_RATIO    4'h4
`define PRSD_OFS_CTRL     4'h8
`define PRSD_AW           4

// ----------------------------------------
// field positions
// ----------------------------------------
`define PRSD_ST_PLAT_LSB  0
`define PRSD_ST_CORE_LSB  4
`define PRSD_ST_PCI64     6
`define PRSD_ST_RSVD      7
`define PRSD_ST_RUN       8
`define PRSD_RT_PLAT_LSB  0
`define PRSD_RT_CORE_LSB  8
`define PRSD_CT_RUN       0
`define PRSD_CT_HI_OUT    1
`define PRSD_CT_LO_OUT    2
`define PRSD_CT_W         3

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define PRSD_CTRL_RST     3'h0
`define PRSD_RESP_OKAY    2'h0
`define PRSD_RESP_SLVERR  2'h2
`define PRSD_ZERO32       32'h0000_0000

// ----------------------------------------
// decode tables, entry per code, code 0 lowest
// ----------------------------------------
`define PRSD_PLAT_W       5
`define PRSD_CORE_W       4
`define PRSD_PLAT_TABLE {5'h00, 5'h00, 5'h00, 5'h0C, 5'h00, 5'h0A, 5'h09, 5'h08, \
                         5'h00, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h00, 5'h10}
`define PRSD_CORE_TABLE   16'h7654
`define PRSD_PLAT_NONE    5'h00

`endif

// ==== rtl/prsd_pkg.sv ====
// Purpose: shared types of the strap decoder
// Assumes: constants come from prsd_map.svh
// Notes: nothing here is imported
package prsd_pkg;

    typedef enum logic [1:0] {
        PRSD_PH_RESET = 2'h0,
        PRSD_PH_LATCH = 2'h1,
        PRSD_PH_RUN   = 2'h3
    } prsd_phase_e;

    typedef struct packed {
        logic [3:0] plat_code;
        logic [1:0] core_code;
        logic       pci_width_pin;
    } prsd_straps_s;

    typedef struct packed {
        logic [4:0] plat_mult;
        logic [3:0] core_x2;
        logic       reserved;
        logic       pci64;
    } prsd_ratio_s;

endpackage

// ==== rtl/prsd_decode.sv ====
// Purpose: table decode of latched strap codes
// Assumes: straps stable once latched
// Notes: purely combinational
`timescale 1ns/1ps
`include "prsd_map.svh"
module prsd_decode (
    input  wire prsd_pkg::prsd_straps_s straps,
    output prsd_pkg::prsd_ratio_s       ratio
);
    localparam logic [79:0] PLAT_TABLE = `PRSD_PLAT_TABLE;
    localparam logic [15:0] CORE_TABLE = `PRSD_CORE_TABLE;

    always_comb begin
        ratio.plat_mult = PLAT_TABLE[straps.plat_code * `PRSD_PLAT_W +: `PRSD_PLAT_W];
        ratio.reserved  = (ratio.plat_mult == `PRSD_PLAT_NONE);
        // core ratio kept as twice its value, so 5:2 stays exact
        ratio.core_x2   = CORE_TABLE[straps.core_code * `PRSD_CORE_W +: `PRSD_CORE_W];
        ratio.pci64     = ~straps.pci_width_pin;
    end
endmodule // prsd_decode

// ==== sim/prsd_assertions.sv ====
// Purpose: port-level checks of the strap decoder
// Assumes: CLK_EN high on at least one edge of every reset
// Notes: bound into prsd_top at the foot of this file
`timescale 1ns/1ps
module prsd_assertions (
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic       CLK_EN,
    input wire logic [3:0] PLAT_RATIO_STRAPS_I,
    input wire logic       CORE_RATIO_STRAP_HIGH_I,
    input wire logic       CORE_RATIO_STRAP_LOW_I,
    input wire logic       PCI_WIDTH_STRAP_I,
    input wire logic       STRAP_PU_EN,
    input wire logic       CORE_RATIO_STRAP_HIGH_OE,
    input wire logic       CORE_RATIO_STRAP_LOW_OE,
    input wire logic       RESET_DRIVEN_O,
    input wire logic       RESET_DRIVEN_OE,
    input wire logic [4:0] PLAT_MULT,
    input wire logic [3:0] CORE_RATIO_X2,
    input wire logic       PLAT_RATIO_RESERVED,
    input wire logic       PCI64,
    input wire logic       L2_CLK_EN,
    input wire logic       MEM_DATA_CLK_EN,
    input wire logic       CORE_COMPLEX_BUS_CLK_EN,
    input wire logic       MEM_BUS_CLK
);
    // ----------------------------------------
    // captured straps and expected decode
    // ----------------------------------------
    localparam logic [15:0] OK_CODES = 16'h177D;
    logic [6:0] cap;
    logic [4:0] mult;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST && CLK_EN) begin
            cap <= {PLAT_RATIO_STRAPS_I, CORE_RATIO_STRAP_HIGH_I, CORE_RATIO_STRAP_LOW_I,
                    PCI_WIDTH_STRAP_I};
        end
    end
    assign mult = !OK_CODES[cap[6:3]] ? 5'h00 : (cap[6:3] == 4'h0) ? 5'h10 : {1'b0, cap[6:3]};
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // three enabled cycles out of reset: decode has landed
    sequence s_run3;
        (!SYS_RST && CLK_EN) [*3];
    endsequence
    AST_PU_OFF: assert property (!SYS_RST && CLK_EN |=> !STRAP_PU_EN)
        else $error("pull-up still on after reset");
    AST_HELD_IN_RESET: assert property ($fell(SYS_RST) |-> RESET_DRIVEN_OE && !RESET_DRIVEN_O
        && STRAP_PU_EN && !CORE_RATIO_STRAP_HIGH_OE && !CORE_RATIO_STRAP_LOW_OE)
        else $error("reset-time pin state wrong");
    AST_PLAT_DECODE: assert property (s_run3 |-> PLAT_MULT == mult
        && PLAT_RATIO_RESERVED == (mult == 5'h00))
        else $error("platform multiplier wrong");
    AST_CORE_DECODE: assert property (s_run3 |-> CORE_RATIO_X2 == {2'b01, cap[2:1]})
        else $error("core ratio wrong");
    AST_PCI_WIDTH: assert property (s_run3 |-> PCI64 == !cap[0])
        else $error("pci width wrong");
    AST_RATIO_HELD: assert property (s_run3 |=> $stable(PLAT_MULT) && $stable(CORE_RATIO_X2))
        else $error("ratio changed while running");
    AST_ONE_PLATFORM_CLK: assert property (L2_CLK_EN == CORE_COMPLEX_BUS_CLK_EN
        && MEM_DATA_CLK_EN == CORE_COMPLEX_BUS_CLK_EN)
        else $error("platform enables disagree");
    AST_MEM_HALF: assert property ((CORE_COMPLEX_BUS_CLK_EN && CLK_EN) [*2]
        |-> MEM_BUS_CLK != $past(MEM_BUS_CLK))
        else $error("memory clock not at half rate");
    AST_OE_AFTER: assert property ((!SYS_RST && CLK_EN) [*5]
        |-> CORE_RATIO_STRAP_HIGH_OE && CORE_RATIO_STRAP_LOW_OE)
        else $error("strap pins not turned to outputs");
    COV_RESERVED: cover property (s_run3 ##0 PLAT_RATIO_RESERVED);
    COV_PCI64: cover property (s_run3 ##0 PCI64);
    COV_MEM_CLK: cover property (CORE_COMPLEX_BUS_CLK_EN [*3]);
endmodule // prsd_assertions

bind prsd_top prsd_assertions u_chk (.CLOCK, .SYS_RST, .CLK_EN, .PLAT_RATIO_STRAPS_I,
    .CORE_RATIO_STRAP_HIGH_I, .CORE_RATIO_STRAP_LOW_I, .PCI_WIDTH_STRAP_I, .STRAP_PU_EN,
    .CORE_RATIO_STRAP_HIGH_OE, .CORE_RATIO_STRAP_LOW_OE, .RESET_DRIVEN_O, .RESET_DRIVEN_OE,
    .PLAT_MULT, .CORE_RATIO_X2, .PLAT_RATIO_RESERVED, .PCI64, .L2_CLK_EN, .MEM_DATA_CLK_EN,
    .CORE_COMPLEX_BUS_CLK_EN, .MEM_BUS_CLK);

// ==== sim/prsd_board.sv ====
// Purpose: board reset logic and strap resistors
// Assumes: code = {platform, core high, core low, pci width}
// Notes: platform and core straps scrambled once reset ends so stale values show
`timescale 1ns/1ps
module prsd_board (
    input  wire logic       CLOCK,
    input  wire logic       SYS_RST,
    input  wire logic [6:0] code,
    input  wire logic       hi_o,
    input  wire logic       hi_oe,
    input  wire logic       lo_o,
    input  wire logic       lo_oe,
    output logic      [3:0] plat,
    output logic            hi,
    output logic            lo,
    output logic            pci
);
    // ----------------------------------------
    // strap drive
    // ----------------------------------------
    logic       flip = 1'b0;
    logic [6:0] drv;
    always_ff @(posedge CLOCK) begin
        flip <= !flip;
    end
    // held all through reset, no default exists
    assign drv = SYS_RST ? code : code ^ {7{flip}} ^ 7'h55;
    assign plat = drv[6:3];
    assign hi = hi_oe ? hi_o : drv[2];
    assign lo = lo_oe ? lo_o : drv[1];
    // driven low in reset for 64-bit, pull-up otherwise
    assign pci = SYS_RST ? code[0] : 1'b1;
endmodule // prsd_board

// ==== sim/prsd_top_tb_top.sv ====
// Purpose: self-checking bench of the strap decoder
// Assumes: one reset per platform code, core and pci bits random
// Notes: reads and write responses checked by the monitor
`timescale 1ns/1ps
module prsd_top_tb_top;
    // ----------------------------------------
    // signals and helpers
    // ----------------------------------------
    logic        clk, rst, en, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, pu, pci;
    logic        hi_i, hi_o, hi_oe, lo_i, lo_o, lo_oe, l2, mdc, ccb;
    logic [3:0]  pl, aa, ws, ara, pc;
    logic [1:0]  br, rr;
    logic [31:0] wd, rd;
    logic [6:0]  code;
    logic [15:0] lfsr;
    logic [33:0] exp_q[$], msk_q[$];
    logic [1:0]  rsp_q[$];
    int          fails, num_checks;

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [4:0] pm(input logic [3:0] c);
        if (c == 4'h0) return 5'h10;
        if (c inside {4'h1, 4'h7, 4'hB, 4'hD, 4'hE, 4'hF}) return 5'h00;
        return {1'b0, c};
    endfunction
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic chk_resp(input logic [1:0] e, input logic [1:0] s);
        chk("bresp", {32'h0, e}, {32'h0, s});
    endtask
    task automatic chk_read(input logic [33:0] e, input logic [33:0] s, input logic [33:0] m);
        chk("read", e & m, s & m);
    endtask
    task automatic chk_pins(input logic [7:0] e, input logic [7:0] s);
        chk("pins", {26'h0, e}, {26'h0, s});
    endtask
    task automatic finish_test;
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        rsp_q.push_back(r);
        aa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(bv && bry)) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        bry <= 1'b0;
        cyc(1);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        while (!(rv && rry)) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end
        rry <= 1'b0;
        cyc(1);
    endtask

    prsd_board u_board (.CLOCK(clk), .SYS_RST(rst), .code(code), .hi_o(hi_o), .hi_oe(hi_oe),
        .lo_o(lo_o), .lo_oe(lo_oe), .plat(pl), .hi(hi_i), .lo(lo_i), .pci(pci));
    prsd_top dut (.CLOCK(clk), .SYS_RST(rst), .CLK_EN(en), .PLAT_RATIO_STRAPS_I(pl),
        .STRAP_PU_EN(pu), .CORE_RATIO_STRAP_HIGH_I(hi_i), .CORE_RATIO_STRAP_HIGH_O(hi_o),
        .CORE_RATIO_STRAP_HIGH_OE(hi_oe), .CORE_RATIO_STRAP_LOW_I(lo_i),
        .CORE_RATIO_STRAP_LOW_O(lo_o), .CORE_RATIO_STRAP_LOW_OE(lo_oe),
        .PCI_WIDTH_STRAP_I(pci), .RESET_DRIVEN_O(), .RESET_DRIVEN_OE(), .PLAT_MULT(),
        .CORE_RATIO_X2(), .PLAT_RATIO_RESERVED(), .PCI64(), .L2_CLK_EN(l2),
        .MEM_DATA_CLK_EN(mdc), .CORE_COMPLEX_BUS_CLK_EN(ccb), .MEM_BUS_CLK(),
        .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rry));

    // ----------------------------------------
    // clock, monitor, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (bv && bry) begin
            chk_resp(rsp_q[0], br);
            rsp_q.delete(0);
        end
        if (rv && rry) begin
            chk_read(exp_q[0], {rr, rd}, msk_q[0]);
            exp_q.delete(0);
            msk_q.delete(0);
        end
    end
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        en = 1'b1;
        {awv, wv, bry, arv, rry} = '0;
        {aa, ws, ara} = '0;
        wd = '0;
        code = '0;
        lfsr = 16'h4E8C;
        for (int i = 0; i < 16; i++) begin
            lfsr = nxt(lfsr);
            pc = 4'(i);
            code <= {pc, lfsr[1:0], lfsr[2]};
            rst <= 1'b1;
            cyc(3);
            rst <= 1'b0;
            cyc(6);
            en <= 1'b0;
            cyc(3);
            en <= 1'b1;
            rd_reg(4'h4, {22'h0, 2'b01, lfsr[1:0], 3'h0, pm(pc)}, '1);
            rd_reg(4'h0, {26'h0, pm(pc) == 5'h0, !lfsr[2], lfsr[1:0], pc}, 34'h3_0000_00FF);
            wr_reg(4'h8, {29'h0, lfsr[5:4], 1'b1}, 4'hF, 2'h0);
            cyc(3);
            chk_pins({3'b011, lfsr[4], lfsr[5], {3{pm(pc) != 5'h0}}},
                {pu, hi_oe, lo_oe, hi_o, lo_o, l2, mdc, ccb});
            wr_reg(4'h8, '0, 4'hE, 2'h0);
            rd_reg(4'h8, {31'h0, lfsr[5:4], 1'b1}, 34'h3_0000_0007);
            wr_reg(4'h0, '1, 4'hF, 2'h2);
            rd_reg(4'hC, {2'h2, 32'h0}, '1);
        end
        finish_test();
    end
endmodule // prsd_top_tb_top
